/* verilog/dqd_consts.vh */
// constants for the dual quadrature decoder: register indexes, fields, resets
// assumes inclusion by bare name from every design file that needs them
`ifndef DQD_CONSTS_VH
`define DQD_CONSTS_VH

// register indexes; the byte address on the bus is four times the index
`define DQD_IDX_CSR 8'h90
`define DQD_IDX_SEL 8'h91
`define DQD_IDX_CNT1 8'h94
`define DQD_IDX_CNT2 8'h96
`define DQD_IDX_DIV 8'h98
`define DQD_IDX_IRQ_STAT 8'h99
`define DQD_IDX_IRQ_EN 8'h9A
`define DQD_IDX_IRQ_CLR 8'h9B

// control/status field positions
`define DQD_CSR_CH2_UP 7
`define DQD_CSR_CH2_DN 6
`define DQD_CSR_CH2_CLR 4
`define DQD_CSR_CH1_UP 3
`define DQD_CSR_CH1_DN 2
`define DQD_CSR_CH1_CLR 0

// input select field positions
`define DQD_SEL_CH2_HI 7
`define DQD_SEL_CH2_LO 6
`define DQD_SEL_CH1_HI 3
`define DQD_SEL_CH1_LO 2
`define DQD_SEL_PRIO_HI 1
`define DQD_SEL_PRIO_LO 0

// port nibble bases: even bit carries quadrature, next odd bit in-phase
`define DQD_CH1_LO_BASE 3'h0
`define DQD_CH1_HI_BASE 3'h4
`define DQD_CH2_LO_BASE 3'h2
`define DQD_CH2_HI_BASE 3'h6

// interrupt status bit positions
`define DQD_IRQ_CH1 0
`define DQD_IRQ_CH2 1

// reset values
`define DQD_SEL_RST 8'h00
`define DQD_DIV_RST 8'h00
`define DQD_IRQ_EN_RST 2'h0

`endif

/* verilog/dqd_sample_timer.v */
// sample timer: one-cycle tick every divisor+2 clocks
// assumes divisor is a register value held steady by software
module dqd_sample_timer #(
  parameter DIV_W = 8
) (
  clk,
  rst,
  divisor,
  tick
);
  input wire clk;
  input wire rst;
  input wire [DIV_W-1:0] divisor;
  output reg tick;

  reg [DIV_W:0] cnt_q;

  // reload counter; the minimum period is two clocks
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= {(DIV_W+1){1'b0}};
      tick <= 1'b0;
    end else if (cnt_q == {(DIV_W+1){1'b0}}) begin
      cnt_q <= {1'b0, divisor} + {{DIV_W{1'b0}}, 1'b1};
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - {{DIV_W{1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // dqd_sample_timer

/* verilog/dqd_channel.v */
// one decoder channel: input select, glitch filter, 4x decode, counter
// assumes port_in synchronous to clk and tick a one-cycle sample strobe
module dqd_channel #(
  parameter CNT_W = 8,
  parameter [2:0] LO_BASE = 3'h0,
  parameter [2:0] HI_BASE = 3'h4
) (
  clk,
  rst,
  tick,
  sel,
  port_in,
  clear,
  count,
  zero_exit,
  wrap_up,
  wrap_dn
);
  input wire clk;
  input wire rst;
  input wire tick;
  input wire [1:0] sel;
  input wire [7:0] port_in;
  input wire clear;
  output reg [CNT_W-1:0] count;
  output reg zero_exit;
  output reg wrap_up;
  output reg wrap_dn;

  reg [1:0] sel_prev_q;
  reg [1:0] smp_q;
  reg [1:0] filt_q;
  wire en = sel[1];
  wire [2:0] base = sel[0] ? HI_BASE : LO_BASE;
  wire [2:0] base_i = base + 3'h1;
  wire [1:0] raw = {port_in[base_i], port_in[base]};
  wire sel_chg = (sel != sel_prev_q);
  // a level is taken only after two equal samples in a row
  wire [1:0] agree = ~(raw ^ smp_q);
  wire [1:0] filt_nx = (agree & raw) | (~agree & filt_q);
  wire [1:0] chg = filt_nx ^ filt_q;
  // both inputs moving in one sample cannot be decoded and is dropped
  wire one_chg = (chg == 2'b01) || (chg == 2'b10);
  wire step = en & tick & ~sel_chg & one_chg;
  wire up = filt_nx[1] ^ filt_q[0];
  wire at_zero = (count == {CNT_W{1'b0}});
  wire at_ones = (count == {CNT_W{1'b1}});

  // filter state; a selection change reloads it silently
  always @(posedge clk) begin
    if (rst) begin
      sel_prev_q <= 2'b00;
      smp_q <= 2'b00;
      filt_q <= 2'b00;
    end else begin
      sel_prev_q <= sel;
      if (sel_chg) begin
        smp_q <= raw;
        filt_q <= raw;
      end else if (en && tick) begin
        smp_q <= raw;
        filt_q <= filt_nx;
      end
    end
  end

  // counter and one-cycle events; a clear wins and raises nothing
  always @(posedge clk) begin
    if (rst) begin
      count <= {CNT_W{1'b0}};
      zero_exit <= 1'b0;
      wrap_up <= 1'b0;
      wrap_dn <= 1'b0;
    end else begin
      zero_exit <= 1'b0;
      wrap_up <= 1'b0;
      wrap_dn <= 1'b0;
      if (clear) begin
        count <= {CNT_W{1'b0}};
      end else if (step) begin
        if (up) begin
          count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
          zero_exit <= at_zero;
          wrap_up <= at_ones;
        end else begin
          count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
          zero_exit <= at_zero;
          wrap_dn <= at_zero;
        end
      end
    end
  end
endmodule // dqd_channel

/* verilog/dqd_top.v */
// dual quadrature decoder top: APB register slave, two channels, interrupt
// assumes an APB master on clk; port_in synchronous to clk
`include "dqd_consts.vh"

module dqd_top #(
  parameter ADDR_W = 12,
  parameter CNT_W = 8,
  parameter DIV_W = 8
) (
  clk,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  port_in,
  irq,
  irq_priority
);
  input wire clk;
  input wire rst;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [ADDR_W-1:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire [7:0] port_in;
  output wire irq;
  output wire [1:0] irq_priority;

  // word decode: index in address bits 9:2, all other bits zero
  function reg_hit;
    input [ADDR_W-1:0] a;
    input [7:0] idx;
    begin
      reg_hit = (a[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) &&
                (a[1:0] == 2'b00) && (a[9:2] == idx);
    end
  endfunction

  // registers held by software
  reg [7:0] sel_q;
  reg [DIV_W-1:0] div_q;
  reg [1:0] irq_en_q;

  // hardware-set state
  reg [3:0] flags_q;
  reg [1:0] irq_stat_q;

  // values captured in the setup cycle of a control/status read
  reg [3:0] cap_flags_q;
  reg [1:0] cap_irq_q;

  // channel outputs
  wire [CNT_W-1:0] cnt1;
  wire [CNT_W-1:0] cnt2;
  wire ch1_zero;
  wire ch1_up;
  wire ch1_dn;
  wire ch2_zero;
  wire ch2_up;
  wire ch2_dn;
  wire tick;

  // bus phases
  wire setup = psel & ~penable;
  wire access = psel & penable;

  // address decode for the current request
  wire hit_csr = reg_hit(paddr, `DQD_IDX_CSR);
  wire hit_sel = reg_hit(paddr, `DQD_IDX_SEL);
  wire hit_cnt1 = reg_hit(paddr, `DQD_IDX_CNT1);
  wire hit_cnt2 = reg_hit(paddr, `DQD_IDX_CNT2);
  wire hit_div = reg_hit(paddr, `DQD_IDX_DIV);
  wire hit_ist = reg_hit(paddr, `DQD_IDX_IRQ_STAT);
  wire hit_ien = reg_hit(paddr, `DQD_IDX_IRQ_EN);
  wire hit_icl = reg_hit(paddr, `DQD_IDX_IRQ_CLR);
  wire mapped = hit_csr | hit_sel | hit_cnt1 | hit_cnt2 |
                hit_div | hit_ist | hit_ien | hit_icl;

  // slave answers in the first access cycle; unmapped gets an error
  assign pready = access;
  assign pslverr = access & ~mapped;

  // completion strobes; a write takes effect only at the access edge
  wire wr_done = access & pwrite & mapped;
  wire wr_csr = wr_done & hit_csr;
  wire wr_sel = wr_done & hit_sel;
  wire wr_div = wr_done & hit_div;
  wire wr_ien = wr_done & hit_ien;
  wire wr_icl = wr_done & hit_icl;
  wire rd_csr = access & ~pwrite & hit_csr;

  // counter clears from the write-only control/status bits
  wire clr1 = wr_csr & pwdata[`DQD_CSR_CH1_CLR];
  wire clr2 = wr_csr & pwdata[`DQD_CSR_CH2_CLR];

  // dedicated sample timer; software sets its constant
  dqd_sample_timer #(
    .DIV_W(DIV_W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .divisor(div_q),
    .tick(tick)
  );

  // channel one on port bits 1:0 or 5:4
  dqd_channel #(
    .CNT_W(CNT_W),
    .LO_BASE(`DQD_CH1_LO_BASE),
    .HI_BASE(`DQD_CH1_HI_BASE)
  ) u_ch1 (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .sel(sel_q[`DQD_SEL_CH1_HI:`DQD_SEL_CH1_LO]),
    .port_in(port_in),
    .clear(clr1),
    .count(cnt1),
    .zero_exit(ch1_zero),
    .wrap_up(ch1_up),
    .wrap_dn(ch1_dn)
  );

  // channel two on port bits 3:2 or 7:6
  dqd_channel #(
    .CNT_W(CNT_W),
    .LO_BASE(`DQD_CH2_LO_BASE),
    .HI_BASE(`DQD_CH2_HI_BASE)
  ) u_ch2 (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .sel(sel_q[`DQD_SEL_CH2_HI:`DQD_SEL_CH2_LO]),
    .port_in(port_in),
    .clear(clr2),
    .count(cnt2),
    .zero_exit(ch2_zero),
    .wrap_up(ch2_up),
    .wrap_dn(ch2_dn)
  );

  // software-written registers; ignored select bits are never stored
  always @(posedge clk) begin
    if (rst) begin
      sel_q <= `DQD_SEL_RST;
      div_q <= `DQD_DIV_RST;
      irq_en_q <= `DQD_IRQ_EN_RST;
    end else begin
      if (wr_sel) begin
        sel_q <= {pwdata[7:6], 2'b00, pwdata[3:0]};
      end
      if (wr_div) begin
        div_q <= pwdata[DIV_W-1:0];
      end
      if (wr_ien) begin
        irq_en_q <= pwdata[1:0];
      end
    end
  end

  // wrap flags in order ch2 up, ch2 down, ch1 up, ch1 down
  wire [3:0] flag_set = {ch2_up, ch2_dn, ch1_up, ch1_dn};
  // only bits actually returned to software are cleared by the read
  wire [3:0] flag_clr = rd_csr ? cap_flags_q : 4'h0;
  wire [3:0] flags_d = (flags_q & ~flag_clr) | flag_set;

  // interrupt sources: a counter stepping out of zero
  wire [1:0] irq_set = {ch2_zero, ch1_zero};
  wire [1:0] irq_clr = (rd_csr ? cap_irq_q : 2'h0) |
                       (wr_icl ? pwdata[1:0] : 2'h0);
  wire [1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  // sticky state; a set in the clearing cycle survives
  always @(posedge clk) begin
    if (rst) begin
      flags_q <= 4'h0;
      irq_stat_q <= 2'h0;
    end else begin
      flags_q <= flags_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  // control/status read value; write-only and unused bits read zero
  wire [7:0] csr_rd = {flags_q[3],
                       flags_q[2],
                       1'b0, 1'b0,
                       flags_q[1], flags_q[0],
                       1'b0, 1'b0};

  // read mux, sampled in the setup cycle
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_csr) begin
      rdata_d[7:0] = csr_rd;
    end else if (hit_sel) begin
      rdata_d[7:0] = sel_q;
    end else if (hit_cnt1) begin
      rdata_d[CNT_W-1:0] = cnt1;
    end else if (hit_cnt2) begin
      rdata_d[CNT_W-1:0] = cnt2;
    end else if (hit_div) begin
      rdata_d[DIV_W-1:0] = div_q;
    end else if (hit_ist) begin
      rdata_d[1:0] = irq_stat_q;
    end else if (hit_ien) begin
      rdata_d[1:0] = irq_en_q;
    end
  end

  // read data register and the snapshot used for clear-on-read
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      cap_flags_q <= 4'h0;
      cap_irq_q <= 2'h0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      cap_flags_q <= (hit_csr & ~pwrite) ? flags_q : 4'h0;
      cap_irq_q <= (hit_csr & ~pwrite) ? irq_stat_q : 2'h0;
    end
  end

  // interrupt line: enabled pending source and a nonzero priority
  assign irq_priority = sel_q[`DQD_SEL_PRIO_HI:`DQD_SEL_PRIO_LO];
  assign irq = (|(irq_stat_q & irq_en_q)) && (irq_priority != 2'b00);
endmodule // dqd_top

/* dv/dqd_props.sv */
// checker for the decoder top: bus handshake, read-zero bits, interrupt priority
// assumes it is bound to dqd_top and sees only its ports
module dqd_props #(
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] port_in,
  input wire irq,
  input wire [1:0] irq_priority
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [ADDR_W-1:0] CSR = 'h240;
  localparam [ADDR_W-1:0] SEL = 'h244;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // bus answer and refusal
  a_ready_now: assert property (psel && penable |-> pready) else $error("no ready");
  a_bus_quiet: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("answer outside access");
  a_mapped_ok: assert property (psel && penable && paddr == CSR |-> !pslverr)
    else $error("mapped address refused");
  a_err_zero: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_prdata_holds: assert property (!psel && $past(!psel) |-> $stable(prdata))
    else $error("read data moved while idle");
  // priority field and its gating of the interrupt
  a_prio_follow: assert property (psel && penable && pwrite && paddr == SEL
    |=> irq_priority == $past(pwdata[1:0])) else $error("priority not taken");
  a_prio_gates: assert property (irq_priority == 2'h0 |-> !irq)
    else $error("interrupt with zero priority");
  // reserved bits read as zero
  a_csr_zero: assert property (psel && !penable && !pwrite && paddr == CSR
    |=> prdata[5:4] == 2'h0 && prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("status zero bits set");
  a_sel_zero: assert property (psel && !penable && !pwrite && paddr == SEL
    |=> prdata[5:4] == 2'h0) else $error("select ignored bits set");
endmodule // dqd_props

bind dqd_top dqd_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_in(port_in), .irq(irq),
  .irq_priority(irq_priority));

/* dv/dqd_enc_model.sv */
// two shaft encoders on the parallel port: in-phase odd bit, quadrature even bit
// assumes step requests set just after a rising clk edge, spaced by the bench
module dqd_enc_model (
  input wire clk,
  input wire [1:0] step,
  input wire [1:0] dir_up,
  input wire glitch,
  output wire [7:0] port_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph1_q = 2'h0;
  logic [1:0] ph2_q = 2'h0;
  // phase to (I,Q): up order 00 10 11 01, one line changes per step
  function automatic logic [1:0] iq(input logic [1:0] p);
    return {p[0] ^ p[1], p[1]};
  endfunction
  // advance each shaft by one quarter cycle on request
  always @(posedge clk) begin
    if (step[0]) ph1_q <= dir_up[0] ? ph1_q + 2'h1 : ph1_q - 2'h1;
    if (step[1]) ph2_q <= dir_up[1] ? ph2_q + 2'h1 : ph2_q - 2'h1;
  end
  // shaft one on bits 5:4 and 1:0, shaft two on 7:6 and 3:2; glitch flips I
  assign port_q = {iq(ph2_q), iq(ph1_q) ^ {glitch, 1'b0}, iq(ph2_q), iq(ph1_q) ^ {glitch, 1'b0}};
endmodule // dqd_enc_model

/* dv/dual_quadrature_decoder_tb.sv */
// self-checking bench for the dual quadrature decoder over its bus
// assumes dqd_top with zero-wait bus and sample tick every 2 clocks after reset
module dual_quadrature_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, glitch = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, last_err;
  logic [1:0] prio, step = 2'h0, dir_up = 2'h0;
  wire [7:0] port;
  int fail_count = 0, comparisons = 0;
  dqd_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_in(port), .irq(irq), .irq_priority(prio));
  dqd_enc_model u_enc (.clk(clk), .step(step), .dir_up(dir_up), .glitch(glitch), .port_q(port));
  // clock of 20 ns
  always #10 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  // one bus transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // this wait ends on the first pready; if pready never comes, only the watchdog ends it
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string n);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(n, r, exp);
  endtask
  // n quarter steps of one shaft, each settled through the filter
  task automatic mv(input int ch, input logic up, input int n);
    repeat (n) begin
      step[ch] <= 1'b1; dir_up[ch] <= up;
      @(posedge clk);
      step[ch] <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic t_reset;
    logic [31:0] r;
    rdchk(12'h244, 32'h0, "sel");
    rdchk(12'h250, 32'h0, "cnt1");
    rdchk(12'h258, 32'h0, "cnt2");
    rdchk(12'h240, 32'h0, "csr");
    apb(1'b0, 12'h300, 32'h0, r);
    chk("unmapped err", last_err, 32'h1);
    chk("unmapped data", r, 32'h0);
    $display("end reset");
  endtask
  task automatic t_ch1;
    wr(12'h244, 32'h89);
    wr(12'h268, 32'h3);
    chk("prio", prio, 32'h1);
    mv(0, 1'b1, 1);
    rdchk(12'h250, 32'h1, "cnt1 up");
    chk("irq up", irq, 32'h1);
    rdchk(12'h264, 32'h1, "irq stat");
    rdchk(12'h240, 32'h0, "csr no wrap");
    chk("irq read", irq, 32'h0);
    mv(0, 1'b0, 2);
    rdchk(12'h250, 32'hFF, "cnt1 dn");
    chk("irq dn", irq, 32'h1);
    rdchk(12'h240, 32'h04, "csr dn1");
    rdchk(12'h240, 32'h00, "csr clr");
    mv(0, 1'b1, 1);
    rdchk(12'h240, 32'h08, "csr up1");
    $display("end ch1");
  endtask
  task automatic t_ch2;
    mv(1, 1'b0, 1);
    rdchk(12'h258, 32'hFF, "cnt2 dn");
    rdchk(12'h240, 32'h40, "csr dn2");
    mv(1, 1'b1, 1);
    rdchk(12'h240, 32'h80, "csr up2");
    rdchk(12'h258, 32'h0, "cnt2 zero");
    $display("end ch2");
  endtask
  task automatic t_clear;
    wr(12'h268, 32'h0);
    mv(0, 1'b1, 3);
    chk("irq masked", irq, 32'h0);
    wr(12'h268, 32'h3);
    chk("irq enabled", irq, 32'h1);
    wr(12'h26C, 32'h1);
    chk("irq cleared", irq, 32'h0);
    mv(1, 1'b1, 2);
    wr(12'h240, 32'h00);
    rdchk(12'h250, 32'h3, "cnt1 keep");
    wr(12'h240, 32'h11);
    rdchk(12'h250, 32'h0, "cnt1 clr");
    rdchk(12'h258, 32'h0, "cnt2 clr");
    rdchk(12'h240, 32'h0, "csr quiet");
    chk("irq quiet", irq, 32'h0);
    $display("end clear");
  endtask
  task automatic t_filter;
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(12'h250, 32'h0, "cnt1 glitch");
    wr(12'h244, 32'h81);
    mv(0, 1'b1, 1);
    rdchk(12'h250, 32'h0, "cnt1 off");
    wr(12'h244, 32'h89);
    repeat (8) @(posedge clk);
    rdchk(12'h250, 32'h0, "cnt1 on");
    $display("end filter");
  endtask
  task automatic t_nibble;
    wr(12'h244, 32'hCD);
    mv(0, 1'b1, 1);
    rdchk(12'h250, 32'h1, "cnt1 hi");
    mv(1, 1'b1, 1);
    rdchk(12'h258, 32'h1, "cnt2 hi");
    for (int p = 0; p < 4; p++) begin
      wr(12'h244, 32'hC8 | p);
      chk("prio loop", prio, p);
    end
    $display("end nibble");
  endtask
  // slower sample timer: period of four clocks still counts one step
  task automatic t_div;
    wr(12'h260, 32'h2);
    rdchk(12'h260, 32'h2, "div");
    mv(0, 1'b1, 1);
    repeat (16) @(posedge clk);
    rdchk(12'h250, 32'h2, "cnt1 slow");
    wr(12'h260, 32'h0);
    $display("end div");
  endtask
  task automatic stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_ch1;
    t_ch2;
    t_clear;
    t_filter;
    t_nibble;
    t_div;
    stop_test;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test;
  end
endmodule // dual_quadrature_decoder_tb
